// ==== include/acs_defs.svh ====
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

`define ACS_TIMER_W 8
`define ACS_TIMER_RESET 8'h00
`define ACS_CODE_LSB 0
`define ACS_CODE_W 3
`define ACS_CHEN_LSB 4
`define ACS_CHEN_W 4
`define ACS_RES_W 12
`define ACS_CLK_MHZ 125
`define ACS_WAKE_NS 1000
`define ACS_WAKE_CYC ((`ACS_WAKE_NS * `ACS_CLK_MHZ + 999) / 1000)
`define ACS_IV1_US 125
`define ACS_IV2_US 250
`define ACS_IV3_US 500
`define ACS_IV4_US 1000
`define ACS_IV5_US 2000
`define ACS_IV6_US 4000
`define ACS_IV7_US 8000

`endif

// ==== include/acs_pkg.sv ====
`include "acs_defs.svh"

package acs_pkg;

    typedef enum logic [1:0] {
        S_OFF = 2'h0,
        S_WAKE = 2'h1,
        S_CONV = 2'h3,
        S_DOWN = 2'h2
    } acs_state_t;

    typedef struct packed {
        logic [`ACS_RES_W-1:0] high;
        logic [`ACS_RES_W-1:0] low;
    } acs_limit_t;

    typedef struct packed {
        logic done;
        logic [`ACS_RES_W-1:0] data;
    } acs_conv_res_t;

    typedef struct packed {
        logic start;
        logic [1:0] channel;
    } acs_conv_req_t;

endpackage

// ==== rtl/acs_scheduler.sv ====
`include "acs_defs.svh"

module acs_scheduler #(
    parameter int unsigned INTERVAL_US [1:7] = '{
        `ACS_IV1_US, `ACS_IV2_US, `ACS_IV3_US, `ACS_IV4_US,
        `ACS_IV5_US, `ACS_IV6_US, `ACS_IV7_US}
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic timer_wr,
    input wire logic [`ACS_TIMER_W-1:0] timer_wr_data,
    input wire logic [7:0] config_reg,
    input wire acs_pkg::acs_limit_t limits,
    input wire acs_pkg::acs_conv_res_t conv_res,
    output logic [`ACS_TIMER_W-1:0] auto_interval_select,
    output acs_pkg::acs_conv_req_t conv_req,
    output logic power_up,
    output logic auto_active,
    output logic result_valid,
    output logic [`ACS_RES_W-1:0] result_data,
    output logic out_of_range
);
    import acs_pkg::*;

    // Interval length in clocks for a nonzero code
    function automatic logic [31:0] interval_cyc(input logic [2:0] code);
        logic [31:0] us;
        us = 32'h1;
        if (code != 3'h0) begin
            us = 32'(INTERVAL_US[code]);
        end
        return us * 32'(`ACS_CLK_MHZ);
    endfunction

    // Next enabled channel above last, else lowest enabled
    function automatic logic [1:0] pick_ch(input logic [3:0] en,
                                           input logic [1:0] last);
        logic [1:0] lo;
        logic [1:0] hi;
        logic found;
        lo = 2'h0;
        hi = 2'h0;
        found = 1'b0;
        for (int i = 3; i >= 0; i--) begin
            if (en[i]) begin
                lo = 2'(i);
            end
            if (en[i] && (2'(i) > last)) begin
                hi = 2'(i);
                found = 1'b1;
            end
        end
        return found ? hi : lo;
    endfunction

    acs_state_t state;
    acs_state_t next_state;
    logic [31:0] cnt;
    logic [7:0] wake_cnt;
    logic [1:0] last_ch;
    logic tick;

    wire [2:0] code = auto_interval_select[`ACS_CODE_LSB +: `ACS_CODE_W];
    wire active = (code != 3'h0);
    wire [3:0] chen = config_reg[`ACS_CHEN_LSB +: `ACS_CHEN_W];
    wire cnt_last = (cnt == interval_cyc(code) - 32'h1);
    wire wake_last = (wake_cnt == 8'(`ACS_WAKE_CYC - 1));
    wire [1:0] next_ch = pick_ch(chen, last_ch);
    wire go = tick && (chen != 4'h0);
    wire conv_end = (state == S_CONV) && conv_res.done;
    wire violation = (conv_res.data > limits.high) ||
                     (conv_res.data < limits.low);

    always_comb begin
        next_state = state;
        unique case (state)
            S_OFF: begin
                if (go) begin
                    next_state = S_WAKE;
                end
            end
            S_WAKE: begin
                if (wake_last) begin
                    next_state = S_CONV;
                end
            end
            S_CONV: begin
                if (conv_res.done) begin
                    next_state = S_DOWN;
                end
            end
            S_DOWN: begin
                next_state = S_OFF;
            end
        endcase
    end

    // Timer register, full byte kept for readback
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_interval_select <= `ACS_TIMER_RESET;
        end else if (timer_wr) begin
            auto_interval_select <= timer_wr_data;
        end
    end

    // Interval counter, restarted by each write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 32'h0;
            tick <= 1'b0;
            auto_active <= 1'b0;
        end else begin
            auto_active <= active;
            tick <= active && cnt_last && !timer_wr;
            if (!active || timer_wr || cnt_last) begin
                cnt <= 32'h0;
            end else begin
                cnt <= cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Wake-up delay and channel pointer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_cnt <= 8'h0;
            last_ch <= 2'h3;
        end else begin
            wake_cnt <= (state == S_WAKE) ? wake_cnt + 8'h1 : 8'h0;
            if (!active && state == S_OFF) begin
                last_ch <= 2'h3;
            end else if (state == S_OFF && go) begin
                last_ch <= next_ch;
            end
        end
    end

    // Converter power and start request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_up <= 1'b0;
            conv_req <= '0;
        end else begin
            conv_req.start <= (state == S_WAKE) && wake_last;
            if (state == S_OFF && go) begin
                power_up <= 1'b1;
                conv_req.channel <= next_ch;
            end else if (conv_end) begin
                power_up <= 1'b0;
            end
        end
    end

    // Result capture and limit check
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_valid <= 1'b0;
            result_data <= '0;
            out_of_range <= 1'b0;
        end else begin
            result_valid <= conv_end;
            if (conv_end) begin
                result_data <= conv_res.data;
                out_of_range <= violation;
            end
        end
    end

    // Checks
    sequence s_done;
        state == S_CONV && conv_res.done;
    endsequence

    sequence s_down;
        !power_up ##1 state == S_OFF;
    endsequence

    property p_upper_ignored;
        @(posedge clk) disable iff (!rst_n)
        (code == 3'h0 && auto_interval_select[7:3] != 5'h0)
            |=> !tick && !auto_active;
    endproperty
    a_upper_ignored: assert property (p_upper_ignored)
        else $error("upper timer bits started the mode");

    property p_tick_cause;
        @(posedge clk) disable iff (!rst_n)
        tick |-> $past(cnt_last) && $past(active) && !$past(timer_wr);
    endproperty
    a_tick_cause: assert property (p_tick_cause)
        else $error("tick without interval expiry");

    property p_stop;
        @(posedge clk) disable iff (!rst_n)
        !active ##1 !active |-> !tick;
    endproperty
    a_stop: assert property (p_stop)
        else $error("tick while interval code is zero");

    property p_power_down;
        @(posedge clk) disable iff (!rst_n)
        s_done |=> s_down;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("converter not powered down after conversion");

    property p_enabled_ch;
        @(posedge clk) disable iff (!rst_n)
        $rose(power_up) |-> chen[conv_req.channel];
    endproperty
    a_enabled_ch: assert property (p_enabled_ch)
        else $error("disabled channel selected");

    property p_wrap;
        @(posedge clk) disable iff (!rst_n)
        (state == S_OFF && go && last_ch == 2'h3 && chen[0])
            |=> conv_req.channel == 2'h0;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("sequence did not wrap to lowest channel");

    property p_wake;
        @(posedge clk) disable iff (!rst_n)
        $rose(power_up) |-> ##[1:200] conv_req.start;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no start after power-up");

    property p_range;
        @(posedge clk) disable iff (!rst_n)
        s_done |=> out_of_range == $past(violation) && result_valid;
    endproperty
    a_range: assert property (p_range)
        else $error("out-of-range flag does not match limits");

    property p_no_chan;
        @(posedge clk) disable iff (!rst_n)
        (state == S_OFF && tick && chen == 4'h0) |=> state == S_OFF;
    endproperty
    a_no_chan: assert property (p_no_chan)
        else $error("conversion with no channel enabled");

endmodule

// ==== test/acs_conv_model.sv ====
module acs_conv_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire acs_pkg::acs_conv_req_t conv_req,
    input wire logic [5:0] lat,
    input wire logic [11:0] data_val,
    output acs_pkg::acs_conv_res_t conv_res
);
    timeunit 1ns;
    timeprecision 1ps;
    import acs_pkg::*;
    logic [5:0] cnt;
    logic busy;
    // Done only after a start; data lines toggle when not valid
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            cnt <= 6'h00;
            conv_res <= '0;
        end else begin
            conv_res.done <= 1'b0;
            conv_res.data <= ~conv_res.data;
            if (conv_req.start) begin
                busy <= 1'b1;
                cnt <= lat;
            end else if (busy && cnt == 6'h00) begin
                busy <= 1'b0;
                conv_res.done <= 1'b1;
                conv_res.data <= data_val;
            end else if (busy) begin
                cnt <= cnt - 6'h01;
            end
        end
    end
endmodule

// ==== test/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import acs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic tw = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [7:0] cfg = 8'h00;
    acs_limit_t lim = '0;
    acs_conv_res_t res;
    acs_conv_req_t req;
    logic [7:0] sel;
    logic pwr, act, rv, oor, eo, pp, d1, d2;
    logic [11:0] rd, ed;
    logic [11:0] dv = 12'h000;
    logic [5:0] lat = 6'h00;
    logic [1:0] ec;
    logic [4:0] up;
    int err_count = 0, num_checks = 0, cyc = 0, nr = 0, nv = 0, tp, tl, n;
    always #4 clk = ~clk;
    acs_scheduler #(.INTERVAL_US('{2, 3, 4, 5, 6, 7, 8})) u_dut (
        .clk(clk), .rst_n(rst_n), .timer_wr(tw), .timer_wr_data(wd),
        .config_reg(cfg), .limits(lim), .conv_res(res),
        .auto_interval_select(sel), .conv_req(req), .power_up(pwr),
        .auto_active(act), .result_valid(rv), .result_data(rd),
        .out_of_range(oor));
    acs_conv_model u_cm (.clk(clk), .rst_n(rst_n), .conv_req(req),
        .lat(lat), .data_val(dv), .conv_res(res));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    function automatic logic [1:0] nxt(logic [3:0] m, logic [1:0] c);
        for (int i = 1; i <= 4; i++) begin
            if (m[(c + i) % 4]) return 2'((c + i) % 4);
        end
        return 2'h0;
    endfunction
    task automatic wr(input logic [7:0] d);
        @(posedge clk);
        tw <= 1'b1;
        wd <= d;
        @(posedge clk);
        tw <= 1'b0;
    endtask
    // Monitor of conversions, results and timeout
    always @(posedge clk) begin
        cyc++;
        if (cyc > 60000) begin
            err_count++;
            end_sim();
        end
        pp <= pwr;
        d1 <= res.done;
        d2 <= d1;
        if (pwr && !pp) begin
            nr++;
            tp = tl;
            tl = cyc;
        end
        if (req.start) begin
            chk(req.channel, ec);
            ec = nxt(cfg[7:4], req.channel);
        end
        if (res.done) begin
            ed = res.data;
            eo = res.data > lim.high || res.data < lim.low;
            dv <= ($urandom_range(2) == 0) ? lim.high : 12'($urandom);
        end
        if (rv) begin
            nv++;
            chk(rd, ed);
            chk(oor, eo);
        end
        if (d2) chk(pwr, 0);
    end
    initial begin
        void'($urandom(7129));
        repeat (3) @(posedge clk);
        chk({sel, req, pwr, act}, 0);
        rst_n <= 1'b1;
        for (int c = 1; c <= 7; c++) begin
            @(posedge clk);
            cfg <= {4'($urandom_range(15, 1)), 4'($urandom)};
            lim <= {12'($urandom), 12'($urandom)};
            lat <= (c % 2 == 1) ? 6'h00 : 6'($urandom);
            @(posedge clk);
            ec = nxt(cfg[7:4], 2'h3);
            wr({5'($urandom), 3'(c)});
            @(posedge clk);
            chk(sel, wd);
            @(posedge clk);
            chk(act, 1);
            n = nr;
            for (int j = 0; j < 3; j++) begin
                while (nr < n + 2 + j) @(posedge clk);
                chk(tl - tp, (c + 1) * 125);
            end
            up = (c % 2 == 1) ? 5'($urandom_range(31, 1)) : 5'h00;
            wr({up, 3'h0});
            @(posedge clk);
            chk(sel, wd);
            while (pwr) @(posedge clk);
            n = nr;
            repeat (1100) @(posedge clk);
            chk(nr, n);
            chk(act, 0);
            chk(nv, nr);
        end
        // No channel enabled: ticks are dropped
        @(posedge clk);
        cfg <= 8'h0f;
        n = nr;
        wr(8'h01);
        repeat (800) @(posedge clk);
        chk(nr, n);
        chk(pwr, 0);
        wr(8'h00);
        end_sim();
    end
endmodule
